// ---- inc/bjcc_defs.svh ----
// Opcode, length, cycle and flag position constants for the executor.
// Assumes a single core clock; included by bare name by the design files.
// What this block does
// - Bit-test-jump-if-set tests the chosen source bit and adds the offset to the PC when it is 1, with no flag change.
// - Opcode 37 is a 3-byte, 10-cycle jump whose second byte is source register, bit index and a low bit of 1.
// - Single-bit XOR folds one selected bit with bit zero of the other operand into the destination, changing nothing else.
// - Opcode 27 is a 3-byte, 6-cycle XOR; low bit 0 targets working register bit zero, 1 targets a register bit.
// - After the XOR, zero follows the result, sign clears, overflow is undefined and the other flags hold.
// - A call pushes the return address low byte then high byte, decrementing the stack pointer before each.
// - A call then loads the PC; F6 is 3 bytes/14 cycles, F4 2 bytes/12 cycles and D4 2 bytes/14 cycles.
// - The memory-indirect call reads its target high byte first from two program bytes at the 8-bit address.
// - Opcode EF is a 1-byte, 4-cycle carry inversion that touches no other flag.
// - Opcodes B0 and B1 write zero to the destination, 2 bytes and 4 cycles, with no flag change.
// - Indirect clear zeroes the register named by the operand register and leaves the pointer alone.
// - Opcodes 60 and 61 invert every destination bit, 2 bytes and 4 cycles.
// - After the complement, zero follows the result, sign is bit 7, overflow clears, the rest hold.
// - Opcode 37 with low bit 0 jumps when the tested bit is 0 instead.
`ifndef BJCC_DEFS_SVH
`define BJCC_DEFS_SVH

`define BJCC_OPC_BIT_JUMP 8'h37
`define BJCC_OPC_BIT_XOR 8'h27
`define BJCC_OPC_CALL_DIRECT 8'hF6
`define BJCC_OPC_CALL_PAIR 8'hF4
`define BJCC_OPC_CALL_MEM 8'hD4
`define BJCC_OPC_CARRY_INV 8'hEF
`define BJCC_OPC_ZERO_REG 8'hB0
`define BJCC_OPC_ZERO_IND 8'hB1
`define BJCC_OPC_COMPL_REG 8'h60
`define BJCC_OPC_COMPL_IND 8'h61

`define BJCC_LEN_ONE 3'h1
`define BJCC_LEN_TWO 3'h2
`define BJCC_LEN_THREE 3'h3

`define BJCC_CYC_BIT_JUMP 4'hA
`define BJCC_CYC_BIT_XOR 4'h6
`define BJCC_CYC_CALL_DIRECT 4'hE
`define BJCC_CYC_CALL_PAIR 4'hC
`define BJCC_CYC_CALL_MEM 4'hE
`define BJCC_CYC_SHORT 4'h4

`define BJCC_FLAG_C 7
`define BJCC_FLAG_Z 6
`define BJCC_FLAG_S 5
`define BJCC_FLAG_V 4

`define BJCC_RESET_BYTE 8'h00
`define BJCC_RESET_WORD 16'h0000

`endif

// ---- inc/bjcc_pkg.sv ----
// Types shared by the executor files.
// Assumes nothing beyond a SystemVerilog compiler.
package bjcc_pkg;
    typedef enum logic [6:0] {
        ST_IDLE = 7'b0000001,
        ST_FETCH_A = 7'b0000010,
        ST_FETCH_B = 7'b0000100,
        ST_FETCH_C = 7'b0001000,
        ST_PUSH_LO = 7'b0010000,
        ST_PUSH_HI = 7'b0100000,
        ST_FINISH = 7'b1000000
    } bjcc_state_e;
endpackage

// ---- hw/bjcc_cycle_timer.sv ----
// Down counter that marks when an instruction's cycle budget is spent.
// Assumes the loading module pulses load in the instruction's first cycle.
module bjcc_cycle_timer (
    input wire logic clock,            // Core clock
    input wire logic rst_n,            // Synchronous reset
    input wire logic load,             // Start of instruction
    input wire logic [3:0] count_init, // Total cycles of the instruction less one
    output logic expired               // Budget used up
);
    logic [3:0] count;

    // Count down to zero after each load
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            count <= 4'h0;
        end else if (load) begin
            count <= count_init;
        end else if (count != 4'h0) begin
            count <= count - 4'h1;
        end
    end

    assign expired = (count == 4'h0);
endmodule // bjcc_cycle_timer

// ---- hw/bjcc_exec.sv ----
// Executor for bit jump, bit XOR, call, carry invert, clear, complement.
// Assumes register file and program memory return read data one cycle
// after the read strobe, and stack writes complete in their cycle.
`include "bjcc_defs.svh"

module bjcc_exec (
    input wire logic clock,             // Core clock, 25 MHz
    input wire logic rst_n,             // Synchronous reset
    input wire logic start,             // Fetch unit hands an instruction
    input wire logic [7:0] opcode,      // First instruction byte
    input wire logic [7:0] operand1,    // Second byte
    input wire logic [7:0] operand2,    // Third byte
    input wire logic [15:0] instr_pc,   // Address of the opcode byte
    input wire logic [7:0] reg_pointer, // Working register bank base
    input wire logic [15:0] sp_in,      // Current stack pointer
    input wire logic [7:0] flags_in,    // Current flag register
    output logic busy,                  // Instruction in progress
    output logic done,                  // Last cycle of instruction
    output logic unsupported,           // Opcode not handled here
    output logic [7:0] reg_addr,        // Register file address
    output logic reg_rd,                // Register read strobe
    input wire logic [7:0] reg_rdata,   // Read data, one cycle later
    output logic reg_wr,                // Register write strobe
    output logic [7:0] reg_wdata,       // Register write data
    output logic [15:0] pmem_addr,      // Program memory address
    output logic pmem_rd,               // Program memory read strobe
    input wire logic [7:0] pmem_rdata,  // Program data, one cycle later
    output logic [15:0] stk_addr,       // Stack memory address
    output logic stk_wr,                // Stack write strobe
    output logic [7:0] stk_wdata,       // Stack write data
    output logic sp_load,               // Take sp_out
    output logic [15:0] sp_out,         // New stack pointer
    output logic flags_wr,              // Take flags_out
    output logic [7:0] flags_out,       // New flag register
    output logic pc_load,               // Take pc_out
    output logic [15:0] pc_out          // Next program counter
);
    bjcc_pkg::bjcc_state_e state;
    logic [7:0] opc, op1, op2, rp, val_a, val_b, flag_base;
    logic [15:0] pc_base, sp_base, ret_pc, rel_pc, call_target;
    logic expired, is_jump, is_xor, is_call, is_mem_call, is_ccf;
    logic is_zero, is_compl, is_ind, needs_b, writes;
    logic jump_bit, xor_bit, start_ok;
    logic [7:0] xor_dst, result;
    logic [2:0] bit_sel;

    // Working register number to register file address
    function automatic logic [7:0] work_reg(input logic [7:0] base,
                                            input logic [3:0] n);
        work_reg = {base[7:4], n};
    endfunction

    // Instruction length in bytes
    function automatic logic [2:0] instr_len(input logic [7:0] o);
        case (o)
            `BJCC_OPC_BIT_JUMP, `BJCC_OPC_BIT_XOR,
            `BJCC_OPC_CALL_DIRECT: instr_len = `BJCC_LEN_THREE;
            `BJCC_OPC_CARRY_INV: instr_len = `BJCC_LEN_ONE;
            default: instr_len = `BJCC_LEN_TWO;
        endcase
    endfunction

    // Cycle budget per opcode
    function automatic logic [3:0] op_cycles(input logic [7:0] o);
        case (o)
            `BJCC_OPC_BIT_JUMP: op_cycles = `BJCC_CYC_BIT_JUMP;
            `BJCC_OPC_BIT_XOR: op_cycles = `BJCC_CYC_BIT_XOR;
            `BJCC_OPC_CALL_DIRECT: op_cycles = `BJCC_CYC_CALL_DIRECT;
            `BJCC_OPC_CALL_PAIR: op_cycles = `BJCC_CYC_CALL_PAIR;
            `BJCC_OPC_CALL_MEM: op_cycles = `BJCC_CYC_CALL_MEM;
            default: op_cycles = `BJCC_CYC_SHORT;
        endcase
    endfunction

    // Opcodes this block executes
    function automatic logic known_op(input logic [7:0] o);
        case (o)
            `BJCC_OPC_BIT_JUMP, `BJCC_OPC_BIT_XOR, `BJCC_OPC_CALL_DIRECT,
            `BJCC_OPC_CALL_PAIR, `BJCC_OPC_CALL_MEM, `BJCC_OPC_CARRY_INV,
            `BJCC_OPC_ZERO_REG, `BJCC_OPC_ZERO_IND, `BJCC_OPC_COMPL_REG,
            `BJCC_OPC_COMPL_IND: known_op = 1'b1;
            default: known_op = 1'b0;
        endcase
    endfunction

    // Opcodes that need no operand read before finishing or pushing
    function automatic logic skips_fetch(input logic [7:0] o);
        skips_fetch = (o == `BJCC_OPC_CALL_DIRECT) ||
                      (o == `BJCC_OPC_CARRY_INV) ||
                      (o == `BJCC_OPC_ZERO_REG);
    endfunction

    // Decode of the latched opcode
    assign is_jump = (opc == `BJCC_OPC_BIT_JUMP);
    assign is_xor = (opc == `BJCC_OPC_BIT_XOR);
    assign is_mem_call = (opc == `BJCC_OPC_CALL_MEM);
    assign is_call = (opc == `BJCC_OPC_CALL_DIRECT) ||
                     (opc == `BJCC_OPC_CALL_PAIR) || is_mem_call;
    assign is_ccf = (opc == `BJCC_OPC_CARRY_INV);
    assign is_zero = (opc == `BJCC_OPC_ZERO_REG) ||
                     (opc == `BJCC_OPC_ZERO_IND);
    assign is_compl = (opc == `BJCC_OPC_COMPL_REG) ||
                      (opc == `BJCC_OPC_COMPL_IND);
    assign is_ind = (opc == `BJCC_OPC_ZERO_IND) ||
                    (opc == `BJCC_OPC_COMPL_IND);
    assign needs_b = is_xor || is_call ||
                     (opc == `BJCC_OPC_COMPL_IND);
    assign writes = is_xor || is_zero || is_compl;
    assign start_ok = start && !busy && known_op(opcode);
    assign bit_sel = op1[3:1];

    // Return address and relative target past the full instruction
    assign ret_pc = pc_base + {13'h0000, instr_len(opc)};
    assign rel_pc = ret_pc + {{8{op2[7]}}, op2};

    // Jump condition: low bit of byte two picks set or clear
    assign jump_bit = val_a[bit_sel];

    // Call target per addressing form, high byte first
    assign call_target = (opc == `BJCC_OPC_CALL_DIRECT) ? {op1, op2}
                       : {val_a, val_b};

    // Bit XOR: val_a is working register, val_b the full register
    always_comb begin
        if (!op1[0]) begin
            xor_bit = val_a[0] ^ val_b[bit_sel];
            xor_dst = {val_a[7:1], xor_bit};
        end else begin
            xor_bit = val_b[bit_sel] ^ val_a[0];
            xor_dst = val_b;
            xor_dst[bit_sel] = xor_bit;
        end
    end

    // Value written back to the destination
    always_comb begin
        if (is_xor) begin
            result = xor_dst;
        end else if (is_compl) begin
            result = is_ind ? ~val_b : ~val_a;
        end else begin
            result = `BJCC_RESET_BYTE;
        end
    end

    // Sequencer
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            state <= bjcc_pkg::ST_IDLE;
        end else begin
            case (state)
                bjcc_pkg::ST_IDLE: begin
                    if (start_ok) begin
                        if (opcode == `BJCC_OPC_CALL_DIRECT) begin
                            state <= bjcc_pkg::ST_PUSH_LO;
                        end else if (skips_fetch(opcode)) begin
                            state <= bjcc_pkg::ST_FINISH;
                        end else begin
                            state <= bjcc_pkg::ST_FETCH_A;
                        end
                    end
                end
                bjcc_pkg::ST_FETCH_A: state <= bjcc_pkg::ST_FETCH_B;
                bjcc_pkg::ST_FETCH_B: begin
                    if (needs_b) begin
                        state <= bjcc_pkg::ST_FETCH_C;
                    end else begin
                        state <= bjcc_pkg::ST_FINISH;
                    end
                end
                bjcc_pkg::ST_FETCH_C: begin
                    state <= is_call ? bjcc_pkg::ST_PUSH_LO
                                     : bjcc_pkg::ST_FINISH;
                end
                bjcc_pkg::ST_PUSH_LO: state <= bjcc_pkg::ST_PUSH_HI;
                bjcc_pkg::ST_PUSH_HI: state <= bjcc_pkg::ST_FINISH;
                bjcc_pkg::ST_FINISH: begin
                    if (expired) begin
                        state <= bjcc_pkg::ST_IDLE;
                    end
                end
                default: state <= bjcc_pkg::ST_IDLE;
            endcase
        end
    end

    // Instruction bytes and machine context taken at start
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            opc <= `BJCC_RESET_BYTE;
            op1 <= `BJCC_RESET_BYTE;
            op2 <= `BJCC_RESET_BYTE;
            rp <= `BJCC_RESET_BYTE;
            flag_base <= `BJCC_RESET_BYTE;
            pc_base <= `BJCC_RESET_WORD;
            sp_base <= `BJCC_RESET_WORD;
        end else if (start_ok) begin
            opc <= opcode;
            op1 <= operand1;
            op2 <= operand2;
            rp <= reg_pointer;
            flag_base <= flags_in;
            pc_base <= instr_pc;
            sp_base <= sp_in;
        end
    end

    // Operand capture one cycle after each read strobe
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            val_a <= `BJCC_RESET_BYTE;
            val_b <= `BJCC_RESET_BYTE;
        end else if (state == bjcc_pkg::ST_FETCH_B) begin
            val_a <= is_mem_call ? pmem_rdata : reg_rdata;
        end else if (state == bjcc_pkg::ST_FETCH_C) begin
            val_b <= is_mem_call ? pmem_rdata : reg_rdata;
        end
    end

    // Unsupported opcode flag, one cycle
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            unsupported <= 1'b0;
        end else begin
            unsupported <= start && !busy && !known_op(opcode);
        end
    end

    bjcc_cycle_timer u_timer (
        .clock(clock),
        .rst_n(rst_n),
        .load(start_ok),
        .count_init(op_cycles(opcode) - 4'h1), // Load edge is cycle one
        .expired(expired)
    );

    assign busy = (state != bjcc_pkg::ST_IDLE);
    assign done = (state == bjcc_pkg::ST_FINISH) && expired;

    // Register and program memory read ports
    always_comb begin
        reg_rd = 1'b0;
        pmem_rd = 1'b0;
        reg_addr = op1;
        pmem_addr = {8'h00, op1};
        case (state)
            bjcc_pkg::ST_FETCH_A: begin
                pmem_rd = is_mem_call;
                reg_rd = !is_mem_call;
                if (is_jump || is_xor) begin
                    reg_addr = work_reg(rp, op1[7:4]);
                end
            end
            bjcc_pkg::ST_FETCH_B: begin
                pmem_rd = needs_b && is_mem_call;
                reg_rd = needs_b && !is_mem_call;
                pmem_addr = {8'h00, op1 + 8'h01};
                if (is_xor) begin
                    reg_addr = op2;
                end else if (is_call) begin
                    reg_addr = op1 + 8'h01;
                end else begin
                    reg_addr = reg_rdata;
                end
            end
            bjcc_pkg::ST_FINISH: begin
                if (is_xor) begin
                    reg_addr = op1[0] ? op2 : work_reg(rp, op1[7:4]);
                end else if (is_ind) begin
                    reg_addr = val_a;
                end
            end
            default: begin
                reg_addr = op1;
            end
        endcase
    end

    // Destination write on the last cycle
    assign reg_wr = done && writes;
    assign reg_wdata = result;

    // Return address push, low byte first
    assign stk_wr = (state == bjcc_pkg::ST_PUSH_LO) ||
                    (state == bjcc_pkg::ST_PUSH_HI);
    assign stk_addr = (state == bjcc_pkg::ST_PUSH_HI)
                    ? sp_base - 16'h0002 : sp_base - 16'h0001;
    assign stk_wdata = (state == bjcc_pkg::ST_PUSH_HI)
                     ? ret_pc[15:8] : ret_pc[7:0];
    assign sp_load = done && is_call;
    assign sp_out = sp_base - 16'h0002;

    // Flag updates
    always_comb begin
        flags_out = flag_base;
        if (is_ccf) begin
            flags_out[`BJCC_FLAG_C] = ~flag_base[`BJCC_FLAG_C];
        end else if (is_xor) begin
            flags_out[`BJCC_FLAG_Z] = ~xor_bit;
            flags_out[`BJCC_FLAG_S] = 1'b0;
        end else if (is_compl) begin
            flags_out[`BJCC_FLAG_Z] = (result == 8'h00);
            flags_out[`BJCC_FLAG_S] = result[7];
            flags_out[`BJCC_FLAG_V] = 1'b0;
        end
    end
    assign flags_wr = done && (is_ccf || is_xor || is_compl);

    // Next program counter
    assign pc_load = done;
    always_comb begin
        if (is_jump && (jump_bit == op1[0])) begin
            pc_out = rel_pc;
        end else if (is_call) begin
            pc_out = call_target;
        end else begin
            pc_out = ret_pc;
        end
    end
endmodule // bjcc_exec

// ---- tb/bjcc_exec_checker.sv ----
// Timing and result assertions for the executor, bound onto its ports.
// Assumes one core clock and the synchronous active-low reset rst_n.
module bjcc_exec_checker (
    input wire logic clock,            // Core clock
    input wire logic rst_n,            // Synchronous reset
    input wire logic start,            // Request pulse
    input wire logic busy,             // In progress
    input wire logic [7:0] opcode,     // First byte
    input wire logic [7:0] operand1,   // Second byte
    input wire logic [7:0] flags_in,   // Flags before
    input wire logic done,             // Last cycle
    input wire logic unsupported,      // Unknown opcode
    input wire logic reg_wr,           // Register write
    input wire logic [7:0] reg_addr,   // Register address
    input wire logic [7:0] reg_wdata,  // Write data
    input wire logic stk_wr,           // Stack write
    input wire logic [15:0] stk_addr,  // Stack address
    input wire logic sp_load,          // Stack pointer load
    input wire logic flags_wr,         // Flag write
    input wire logic [7:0] flags_out,  // New flags
    input wire logic pc_load           // PC load
);
    timeunit 1ns;
    timeprecision 1ns;
    logic take;
    // Request made while the executor is idle, known opcode or not
    assign take = start && !busy;
    default clocking @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    jump_cycles_a: assert property (take && opcode == 8'h37 |-> ##10 done)
        else $error("bit jump did not end after ten cycles");
    jump_quiet_a: assert property (take && opcode == 8'h37 |=> (!flags_wr && !reg_wr) [*8])
        else $error("bit jump wrote flags or a register");
    xor_end_a: assert property (take && opcode == 8'h27 |-> ##6 done && reg_wr && flags_wr && !flags_out[5])
        else $error("bit xor end wrong");
    call_pair_a: assert property (take && opcode == 8'hF4 |-> ##12 done && sp_load)
        else $error("pair call length wrong");
    call_long_a: assert property (take && (opcode == 8'hF6 || opcode == 8'hD4) |-> ##14 done && sp_load)
        else $error("long call length wrong");
    push_order_a: assert property (stk_wr && !$past(stk_wr) |=> stk_wr && stk_addr == $past(stk_addr) - 16'h1)
        else $error("second push not one below first");
    carry_inv_a: assert property (take && opcode == 8'hEF |-> ##4 done && flags_wr && flags_out == ($past(flags_in, 4) ^ 8'h80))
        else $error("carry inversion wrong");
    zero_reg_a: assert property (take && opcode == 8'hB0 |-> ##4 reg_wr && reg_wdata == 8'h00 && !flags_wr && reg_addr == $past(operand1, 4))
        else $error("register clear wrong");
    refuse_op_a: assert property (take && opcode == 8'h00 |=> unsupported && !busy)
        else $error("unknown opcode not refused");
    done_pc_a: assert property (done |-> pc_load && busy)
        else $error("done without pc load");
    cover property (take && opcode == 8'h37);
    cover property (stk_wr ##1 stk_wr);
    cover property (unsupported);
endmodule // bjcc_exec_checker

bind bjcc_exec bjcc_exec_checker i_bjcc_exec_checker (.clock(clock), .rst_n(rst_n),
    .start(start), .busy(busy), .opcode(opcode), .operand1(operand1),
    .flags_in(flags_in), .done(done), .unsupported(unsupported),
    .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .stk_wr(stk_wr), .stk_addr(stk_addr), .sp_load(sp_load),
    .flags_wr(flags_wr), .flags_out(flags_out), .pc_load(pc_load));

// ---- tb/bjcc_mem_model.sv ----
// Register file, program memory and stack memory beside the executor.
// Assumes reads answer one cycle after the strobe; bench preloads arrays.
module bjcc_mem_model (
    input wire logic clock,            // Core clock
    input wire logic [7:0] reg_addr,   // Register address
    input wire logic reg_rd,           // Register read
    output logic [7:0] reg_rdata,      // Register data
    input wire logic reg_wr,           // Register write
    input wire logic [7:0] reg_wdata,  // Write data
    input wire logic [15:0] pmem_addr, // Program address
    input wire logic pmem_rd,          // Program read
    output logic [7:0] pmem_rdata,     // Program data
    input wire logic [15:0] stk_addr,  // Stack address
    input wire logic stk_wr,           // Stack write
    input wire logic [7:0] stk_wdata   // Stack data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] regs [0:255];
    logic [7:0] pmem [0:255];
    logic [7:0] stk [0:255];
    initial begin
        reg_rdata = 8'h00;
        pmem_rdata = 8'h00;
    end
    // Reads answer next cycle; idle data toggles so stale reads show
    always @(posedge clock) begin
        reg_rdata <= reg_rd ? regs[reg_addr] : ~reg_rdata;
        pmem_rdata <= pmem_rd ? pmem[pmem_addr[7:0]] : ~pmem_rdata;
        if (reg_wr) begin
            regs[reg_addr] <= reg_wdata;
        end
        if (stk_wr) begin
            stk[stk_addr[7:0]] <= stk_wdata;
        end
    end
endmodule // bjcc_mem_model

// ---- tb/bjcc_exec_tb.sv ----
// Self-checking bench for the executor with its memory model.
// Assumes working registers at 8'hC0 and a stack pointer of 16'h0002.
module bjcc_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [7:0] op, o1, o2;
        logic [3:0] cy;
        logic [15:0] pe;
        logic fw;
        logic [7:0] fe;
    } bjcc_row_s;
    logic clock = 1'b0, rst_n = 1'b0, start = 1'b0;
    logic [7:0] opcode = 8'h00, operand1 = 8'h00, operand2 = 8'h00;
    logic [15:0] instr_pc = 16'h1A47, sp_in = 16'h0002;
    logic [7:0] reg_pointer = 8'hC0, flags_in = 8'h1F;
    logic busy, done, unsupported, reg_rd, reg_wr, pmem_rd, stk_wr;
    logic sp_load, flags_wr, pc_load, fw_s;
    logic [7:0] reg_addr, reg_rdata, reg_wdata, pmem_rdata, stk_wdata;
    logic [7:0] flags_out, fl_s;
    logic [15:0] pmem_addr, stk_addr, sp_out, pc_out, pc_s, sp_s;
    int failures = 0, samples_checked = 0, n;
    bjcc_row_s rows [15] = '{
        '{8'h37, 8'h13, 8'h10, 4'hA, 16'h1A5A, 1'b0, 8'h00},
        '{8'h37, 8'h17, 8'h7F, 4'hA, 16'h1A4A, 1'b0, 8'h00},
        '{8'h37, 8'h16, 8'h7F, 4'hA, 16'h1AC9, 1'b0, 8'h00},
        '{8'h37, 8'h16, 8'h80, 4'hA, 16'h19CA, 1'b0, 8'h00},
        '{8'h37, 8'h12, 8'h80, 4'hA, 16'h1A4A, 1'b0, 8'h00},
        '{8'h27, 8'h15, 8'h01, 4'h6, 16'h1A4A, 1'b1, 8'h0F},
        '{8'h27, 8'h12, 8'h01, 4'h6, 16'h1A4A, 1'b1, 8'h4F},
        '{8'hF6, 8'h35, 8'h21, 4'hE, 16'h3521, 1'b0, 8'h00},
        '{8'hF4, 8'h20, 8'h00, 4'hC, 16'h3521, 1'b0, 8'h00},
        '{8'hD4, 8'h40, 8'h00, 4'hE, 16'h3521, 1'b0, 8'h00},
        '{8'hEF, 8'h00, 8'h00, 4'h4, 16'h1A48, 1'b1, 8'h9F},
        '{8'hB0, 8'h30, 8'h00, 4'h4, 16'h1A49, 1'b0, 8'h00},
        '{8'hB1, 8'h31, 8'h00, 4'h4, 16'h1A49, 1'b0, 8'h00},
        '{8'h60, 8'h33, 8'h00, 4'h4, 16'h1A49, 1'b1, 8'h4F},
        '{8'h61, 8'h34, 8'h00, 4'h4, 16'h1A49, 1'b1, 8'h2F}};
    // Core clock, 40 ns period
    always #20 clock = ~clock;
    bjcc_exec i_bjcc_exec (.clock(clock), .rst_n(rst_n), .start(start),
        .opcode(opcode), .operand1(operand1), .operand2(operand2),
        .instr_pc(instr_pc), .reg_pointer(reg_pointer), .sp_in(sp_in),
        .flags_in(flags_in), .busy(busy), .done(done),
        .unsupported(unsupported), .reg_addr(reg_addr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .pmem_addr(pmem_addr), .pmem_rd(pmem_rd), .pmem_rdata(pmem_rdata),
        .stk_addr(stk_addr), .stk_wr(stk_wr), .stk_wdata(stk_wdata),
        .sp_load(sp_load), .sp_out(sp_out), .flags_wr(flags_wr),
        .flags_out(flags_out), .pc_load(pc_load), .pc_out(pc_out));
    bjcc_mem_model i_bjcc_mem_model (.clock(clock), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .pmem_addr(pmem_addr), .pmem_rd(pmem_rd),
        .pmem_rdata(pmem_rdata), .stk_addr(stk_addr), .stk_wr(stk_wr),
        .stk_wdata(stk_wdata));
    // Compare and count
    task check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task stop_test;
        $display("checked %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One cycle start pulse; returns one nanosecond into cycle 1
    task go(input logic [7:0] op, input logic [7:0] a, input logic [7:0] b);
        @(posedge clock);
        #1;
        start = 1'b1;
        opcode = op;
        operand1 = a;
        operand2 = b;
        @(posedge clock);
        #1;
        start = 1'b0;
    endtask
    // Bounded wait for done, capturing the committed values
    task wait_done;
        n = 1;
        while (done !== 1'b1) begin
            @(posedge clock);
            #1;
            n++;
            if (n > 40) begin
                failures++;
                stop_test();
            end
        end
        pc_s = pc_out;
        fl_s = flags_out;
        fw_s = flags_wr;
        sp_s = sp_out;
    endtask
    initial begin
        i_bjcc_mem_model.regs[8'hC1] = 8'h07;
        i_bjcc_mem_model.regs[8'h01] = 8'h03;
        i_bjcc_mem_model.regs[8'h20] = 8'h35;
        i_bjcc_mem_model.regs[8'h21] = 8'h21;
        i_bjcc_mem_model.regs[8'h31] = 8'h32;
        i_bjcc_mem_model.regs[8'h32] = 8'h5E;
        i_bjcc_mem_model.regs[8'h33] = 8'hFF;
        i_bjcc_mem_model.regs[8'h34] = 8'h35;
        i_bjcc_mem_model.regs[8'h35] = 8'h0F;
        i_bjcc_mem_model.pmem[8'h40] = 8'h35;
        i_bjcc_mem_model.pmem[8'h41] = 8'h21;
        repeat (20) @(posedge clock);
        #1;
        rst_n = 1'b1;
        check({busy, done, reg_wr, stk_wr, pc_load}, 16'h0);
        $display("test reset done");
        // Offsets stay within -128..+127 by construction
        foreach (rows[i]) begin
            go(rows[i].op, rows[i].o1, rows[i].o2);
            wait_done();
            check(n, rows[i].cy);
            check(pc_s, rows[i].pe);
            check(fw_s, rows[i].fw);
            if (rows[i].fw) check(fl_s & (rows[i].op == 8'h27 ? 8'hEF : 8'hFF), rows[i].fe);
            $display("test row %0d done", i);
        end
        @(posedge clock);
        #1;
        check(i_bjcc_mem_model.regs[8'h01], 8'h07);
        check(i_bjcc_mem_model.regs[8'hC1], 8'h06);
        check(i_bjcc_mem_model.regs[8'h30], 8'h00);
        check(i_bjcc_mem_model.regs[8'h31], 8'h32);
        check(i_bjcc_mem_model.regs[8'h32], 8'h00);
        check(i_bjcc_mem_model.regs[8'h33], 8'h00);
        check(i_bjcc_mem_model.regs[8'h35], 8'hF0);
        check({i_bjcc_mem_model.stk[0], i_bjcc_mem_model.stk[1]}, 16'h1A49);
        check(sp_s, 16'h0000);
        $display("test results done");
        // Start held high into the busy cycle with a new opcode
        @(posedge clock);
        #1;
        start = 1'b1;
        opcode = 8'hEF;
        operand1 = 8'h00;
        @(posedge clock);
        #1;
        opcode = 8'hB0;
        operand1 = 8'h30;
        @(posedge clock);
        #1;
        start = 1'b0;
        wait_done();
        check(n + 1, 4);
        check(fw_s, 1'b1);
        n = 0;
        repeat (6) begin
            @(posedge clock);
            #1;
            n += done;
        end
        check(n, 0);
        $display("test busy refuse done");
        go(8'h00, 8'h00, 8'h00);
        check({unsupported, busy}, 2'b10);
        $display("test unsupported done");
        go(8'hF6, 8'h35, 8'h21);
        repeat (3) @(posedge clock);
        #1;
        rst_n = 1'b0;
        @(posedge clock);
        #1;
        check({busy, done, stk_wr, sp_load}, 4'h0);
        rst_n = 1'b1;
        go(8'hEF, 8'h00, 8'h00);
        wait_done();
        check(n, 4);
        $display("test mid reset done");
        stop_test();
    end
endmodule // bjcc_exec_tb
